/* File: rtl/ddi_ctrl.sv */
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/100ps
module ddi_ctrl #(
    parameter int ADDR_W = 24
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [ddi_pkg::HADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic acc_req,
    input wire logic [27:0] acc_addr,
    input wire logic acc_write,
    input wire logic acc_area,
    input wire logic [1:0] acc_be,
    input wire logic [15:0] acc_wdata,
    output logic acc_ack,
    output logic [15:0] acc_rdata,
    output logic acc_rvalid,
    input wire logic refresh_tick,
    input wire logic ext_bus_req,
    input wire logic cpu_standby,
    output logic [ADDR_W-1:0] dram_addr,
    output logic [15:0] dram_wdata,
    output logic dram_data_oe,
    input wire logic [15:0] dram_rdata_in,
    output logic [3:0] row_strobe_n,
    output logic high_col_strobe_n,
    output logic low_col_strobe_n,
    output logic dram_read_strobe_n,
    output logic dram_write_strobe_n
);
    import ddi_pkg::*;

    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta_reg;
    logic rst_n;
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // ****************************************
    // address helpers
    // ****************************************
    function automatic logic [27:0] row_of(logic [27:0] a, logic [1:0] cs);
        logic [38:0] w;
        w = {11'h7ff, a} >> (4'h8 + {2'h0, cs});
        return w[27:0];
    endfunction

    function automatic logic [27:0] col_of(logic [27:0] a, logic [1:0] cs);
        logic [10:0] m;
        m = 11'h7ff >> (2'h3 - cs);
        return {17'h0, a[10:0] & m};
    endfunction

    // ****************************************
    // register slave
    // ****************************************
    logic [15:0] bus_control_reg;
    logic [15:0] dram_timing_reg;
    logic wr_pend_reg;
    logic rd_wait_reg;
    logic [1:0] sel_reg;
    logic [2:0] size_reg;
    logic [1:0] lane_reg;
    logic [15:0] status;
    logic [15:0] rd_mux;
    logic take;
    logic [1:0] sel;
    ddi_state_e state_reg;
    logic ref_pend_reg;

    assign take = hsel && hready && htrans[1];
    assign hresp = 1'b0;
    // reads wait one cycle so a write just ahead is always seen
    assign hreadyout = !rd_wait_reg;

    always_comb
    begin
        sel = 2'h0;
        if (haddr[31:2] == {10'h0, BUS_CONTROL_IDX})
            sel = 2'h1;
        else if (haddr[31:2] == {10'h0, DRAM_TIMING_IDX})
            sel = 2'h2;
        else if (haddr[31:2] == {10'h0, DRAM_STATUS_IDX})
            sel = 2'h3;
    end

    assign status = {9'h0, ref_pend_reg, state_reg == S_OPEN,
                     state_reg == S_SELF, state_reg};

    always_comb
    begin
        case (sel_reg)
            2'h1: rd_mux = bus_control_reg;
            2'h2: rd_mux = dram_timing_reg;
            2'h3: rd_mux = status;
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend_reg <= 1'b0;
            rd_wait_reg <= 1'b0;
            sel_reg <= 2'h0;
            size_reg <= 3'h0;
            lane_reg <= 2'h0;
            hrdata <= 32'h0;
        end
        else
        begin
            wr_pend_reg <= take && hwrite;
            rd_wait_reg <= take && !hwrite;
            if (take)
            begin
                sel_reg <= sel;
                size_reg <= hsize;
                lane_reg <= haddr[1:0];
            end
            if (rd_wait_reg)
                hrdata <= {16'h0, rd_mux};
        end
    end

    // one register set serves every DRAM area
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_control_reg <= BUS_CONTROL_RST;
            dram_timing_reg <= DRAM_TIMING_RST;
        end
        else if (wr_pend_reg && sel_reg == 2'h1)
        begin
            if (size_reg == HSIZE_BYTE && lane_reg == 2'h0)
                bus_control_reg[7:0] <= hwdata[7:0] & BUS_CONTROL_MASK[7:0];
            else if (size_reg == HSIZE_BYTE && lane_reg == 2'h1)
                bus_control_reg[15:8] <= hwdata[15:8]
                                         & BUS_CONTROL_MASK[15:8];
            else if (size_reg != HSIZE_BYTE && !lane_reg[1])
                bus_control_reg <= hwdata[15:0] & BUS_CONTROL_MASK;
        end
        else if (wr_pend_reg && sel_reg == 2'h2)
        begin
            // low byte lands in both halves, high byte alone is dropped
            if (size_reg == HSIZE_BYTE && lane_reg == 2'h0)
                dram_timing_reg <= {hwdata[7:0], hwdata[7:0]}
                                   & DRAM_TIMING_MASK;
            else if (size_reg != HSIZE_BYTE && !lane_reg[1])
                dram_timing_reg <= hwdata[15:0] & DRAM_TIMING_MASK;
        end
    end

    logic edo_on;
    logic [1:0] col_sel;
    logic ref_en;
    logic ref_self;
    logic [2:0] rpc_m1;
    logic [2:0] rra_m1;
    logic area_hi;
    logic keep_open;
    logic [2:0] prc_m1;
    logic [2:0] cas_m1;
    logic [2:0] ras_m1;
    assign edo_on = bus_control_reg[EDO_BIT];
    assign col_sel = bus_control_reg[COL_LSB +: 2];
    assign ref_en = bus_control_reg[REF_EN_BIT];
    assign ref_self = bus_control_reg[REF_METH_BIT];
    assign rpc_m1 = {2'h0, bus_control_reg[RCAS_DLY_BIT]};
    assign rra_m1 = {1'b0, bus_control_reg[RRA_LSB +: 2]} + 3'h1;
    assign area_hi = dram_timing_reg[AREA_BIT];
    assign keep_open = dram_timing_reg[KEEP_BIT];
    assign prc_m1 = {1'b0, dram_timing_reg[PRC_LSB +: 2]};
    assign cas_m1 = {1'b0, dram_timing_reg[CAS_COUNT_SEL_LSB +: 2]};
    assign ras_m1 = {1'b0, dram_timing_reg[RAS_COUNT_SEL_LSB +: 2]};

    // ****************************************
    // refresh request
    // ****************************************
    logic self_want;
    logic ref_go;
    assign self_want = ref_en && ref_self;
    assign ref_go = ref_pend_reg || self_want;

    // a tick in the very cycle the pending flag is taken is kept
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            ref_pend_reg <= 1'b0;
        else if (refresh_tick && ref_en && !ref_self)
            ref_pend_reg <= 1'b1;
        else if (state_reg == S_RFD || !ref_en)
            ref_pend_reg <= 1'b0;
    end

    // ****************************************
    // access sequencer
    // ****************************************
    logic [2:0] cnt_reg;
    logic [27:0] addr_reg;
    logic area_reg;
    logic write_reg;
    logic [1:0] be_reg;
    logic sx_reg;
    logic edo_pend_reg;
    logic [27:0] row_req;
    logic [27:0] row_held;
    logic [27:0] col_req;
    logic [27:0] col_held;
    logic same_page;
    assign row_req = row_of(acc_addr, col_sel);
    assign row_held = row_of(addr_reg, col_sel);
    assign col_req = col_of(acc_addr, col_sel);
    assign col_held = col_of(addr_reg, col_sel);
    assign same_page = row_req == row_held && acc_area == area_reg;

    // wait input is absent on purpose: cycle length is counts only
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= S_IDLE;
            cnt_reg <= 3'h0;
            addr_reg <= 28'h0;
            area_reg <= 1'b0;
            write_reg <= 1'b0;
            be_reg <= 2'h0;
            sx_reg <= 1'b0;
            acc_ack <= 1'b0;
            dram_addr <= '0;
            dram_wdata <= 16'h0;
        end
        else
        begin
            acc_ack <= 1'b0;
            case (state_reg)
                S_IDLE:
                begin
                    if (ref_go)
                    begin
                        state_reg <= S_RFD;
                        cnt_reg <= rpc_m1;
                        sx_reg <= 1'b0;
                    end
                    else if (acc_req)
                    begin
                        state_reg <= S_RAS;
                        cnt_reg <= ras_m1;
                        sx_reg <= 1'b0;
                        addr_reg <= acc_addr;
                        area_reg <= acc_area;
                        write_reg <= acc_write;
                        be_reg <= acc_be;
                        dram_wdata <= acc_wdata;
                        dram_addr <= row_req[ADDR_W-1:0];
                    end
                end
                S_RAS:
                begin
                    if (cnt_reg == 3'h0)
                    begin
                        state_reg <= S_CAS;
                        cnt_reg <= cas_m1;
                        dram_addr <= col_held[ADDR_W-1:0];
                    end
                    else
                        cnt_reg <= cnt_reg - 3'h1;
                end
                S_CAS:
                begin
                    if (cnt_reg == 3'h0)
                    begin
                        acc_ack <= 1'b1;
                        if (keep_open)
                            state_reg <= S_GAPE;
                        else
                        begin
                            state_reg <= S_PRE;
                            cnt_reg <= prc_m1;
                        end
                    end
                    else
                        cnt_reg <= cnt_reg - 3'h1;
                end
                S_GAPE: state_reg <= S_OPEN;
                S_OPEN:
                begin
                    // row stays open while nothing closes it
                    if (ref_go || ext_bus_req || cpu_standby
                        || (acc_req && !same_page))
                    begin
                        state_reg <= S_PRE;
                        cnt_reg <= prc_m1;
                    end
                    else if (acc_req)
                    begin
                        state_reg <= S_GAPS;
                        addr_reg <= acc_addr;
                        write_reg <= acc_write;
                        be_reg <= acc_be;
                        dram_wdata <= acc_wdata;
                        dram_addr <= col_req[ADDR_W-1:0];
                    end
                end
                S_GAPS:
                begin
                    state_reg <= S_CAS;
                    cnt_reg <= cas_m1;
                end
                S_PRE:
                begin
                    if (cnt_reg == 3'h0)
                        state_reg <= S_IDLE;
                    else
                        cnt_reg <= cnt_reg - 3'h1;
                end
                S_RFD:
                begin
                    if (cnt_reg == 3'h0 && ref_self)
                        state_reg <= S_SELF;
                    else if (cnt_reg == 3'h0)
                    begin
                        state_reg <= S_RFR;
                        cnt_reg <= rra_m1;
                    end
                    else
                        cnt_reg <= cnt_reg - 3'h1;
                end
                S_RFR:
                begin
                    if (cnt_reg == 3'h0)
                    begin
                        state_reg <= S_PRE;
                        cnt_reg <= prc_m1;
                    end
                    else
                        cnt_reg <= cnt_reg - 3'h1;
                end
                S_SELF:
                begin
                    if (!self_want)
                    begin
                        state_reg <= S_PRE;
                        cnt_reg <= SELF_EXIT_PRE_M1;
                        sx_reg <= 1'b1;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // ****************************************
    // read data capture
    // ****************************************
    // single clock: the half-cycle EDO lag is taken as one full edge later
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            edo_pend_reg <= 1'b0;
            acc_rvalid <= 1'b0;
            acc_rdata <= 16'h0;
        end
        else
        begin
            edo_pend_reg <= 1'b0;
            acc_rvalid <= 1'b0;
            if (state_reg == S_CAS && cnt_reg == 3'h0 && !write_reg)
            begin
                if (edo_on)
                    edo_pend_reg <= 1'b1;
                else
                begin
                    acc_rdata <= dram_rdata_in;
                    acc_rvalid <= 1'b1;
                end
            end
            if (edo_pend_reg)
            begin
                acc_rdata <= dram_rdata_in;
                acc_rvalid <= 1'b1;
            end
        end
    end

    // ****************************************
    // strobes
    // ****************************************
    logic row_low;
    logic all_low;
    logic cas_on;
    assign row_low = state_reg inside {S_RAS, S_CAS, S_GAPE, S_OPEN, S_GAPS};
    assign all_low = state_reg inside {S_RFR, S_SELF};
    assign cas_on = state_reg == S_CAS;
    // upper area pair takes strobe slots 2 and 3
    assign row_strobe_n = all_low ? 4'h0 :
        row_low ? ~(4'h1 << {area_hi, area_reg}) : 4'hf;
    assign high_col_strobe_n = !(all_low || (cas_on && be_reg[1]));
    assign low_col_strobe_n = !(all_low || (cas_on && be_reg[0]));
    // edo data is taken one edge late, so the read strobe keeps it driven
    assign dram_read_strobe_n = !((cas_on || edo_pend_reg) && !write_reg);
    assign dram_write_strobe_n = !(cas_on && write_reg);
    assign dram_data_oe = cas_on && write_reg;

    // ****************************************
    // checks
    // ****************************************
    ddi_state_e prev_reg;
    logic [3:0] run_reg;
    logic leave;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_reg <= S_IDLE;
            run_reg <= 4'h0;
        end
        else
        begin
            prev_reg <= state_reg;
            if (state_reg != prev_reg)
                run_reg <= 4'h1;
            else if (run_reg != 4'hf)
                run_reg <= run_reg + 4'h1;
        end
    end
    assign leave = state_reg != prev_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_RAS_LEN: assert property (leave && prev_reg == S_RAS
        |-> run_reg == {1'b0, ras_m1} + 4'h1) else $error("ras length");
    AST_CAS_LEN: assert property (leave && prev_reg == S_CAS
        |-> run_reg == {1'b0, cas_m1} + 4'h1) else $error("cas length");
    AST_PRE_LEN: assert property (leave && prev_reg == S_PRE && !sx_reg
        |-> run_reg == {1'b0, prc_m1} + 4'h1) else $error("pre length");
    AST_SELF_PRE: assert property (leave && prev_reg == S_PRE && sx_reg
        |-> run_reg == 4'h6) else $error("self exit precharge");
    AST_RFR_LEN: assert property (leave && prev_reg == S_RFR
        |-> run_reg == {1'b0, rra_m1} + 4'h1) else $error("refresh width");
    AST_ROW_ADDR: assert property (state_reg == S_RAS
        |-> dram_addr == row_held[ADDR_W-1:0]) else $error("row address");
    AST_OPEN_HOLD: assert property (state_reg == S_OPEN
        |-> row_strobe_n != 4'hf && low_col_strobe_n) else $error("row open");
    AST_OPEN_EXIT: assert property (state_reg == S_OPEN && ext_bus_req
        |=> state_reg == S_PRE ##1 row_strobe_n == 4'hf)
        else $error("row not closed");
    AST_EDO_LAG: assert property (acc_ack && !write_reg && edo_on
        |-> !acc_rvalid ##1 acc_rvalid) else $error("edo capture");
    AST_SELF_END: assert property (state_reg == S_SELF && !self_want
        |=> state_reg == S_PRE && high_col_strobe_n)
        else $error("self exit");

    COV_PAGE_HIT: cover property (state_reg == S_GAPS ##1 state_reg == S_CAS);
    COV_CBR: cover property (state_reg == S_RFR ##1 state_reg == S_PRE);
    COV_SELF: cover property (state_reg == S_SELF ##1 state_reg == S_PRE);
endmodule

/* File: rtl/ddi_pkg.sv */
package ddi_pkg;
// Summary of operation
// - one shared set of DRAM settings covers all four DRAM-capable areas.
// - edo_page_select 1 runs EDO page mode, 0 runs fast page mode.
// - keep_row_open_mode holds row strobe low between accesses, no precharge.
// - an idle cycle is inserted before each page-hit access and after each keep-open access.
// - refresh, bus request, other page or standby close the row with precharge.
// - column_size_sel picks column width 8, 9, 10 or 11 bits.
// - row address is the address shifted right by column width, ones filled.
// - column address is the unshifted low address bits, driven with CAS.
// - refresh_enable_bit turns internal refresh on, off after reset.
// - refresh_method_sel 1 picks self-refresh, 0 CAS-before-RAS.
// - each timer underflow gives one CAS-before-RAS refresh when enabled.
// - self-refresh runs while both refresh bits are 1, ends when one clears.
// - refresh CAS delay after precharge is 2 cycles when set, else 1.
// - refresh row strobe low time is 2, 3, 4 or 5 cycles.
// - row precharge lasts 1, 2, 3 or 4 cycles.
// - column strobe lasts 1, 2, 3 or 4 cycles per access.
// - row strobe phase lasts 1, 2, 3 or 4 cycles per access.
// - timing byte write at low byte sets both bytes, at high byte nothing.
// - the external wait input plays no part in DRAM cycles.
// - EDO read data is taken later than in fast page mode.
// - dram_area_select moves DRAM row strobes to the upper area pair.
// - self-refresh exit raises both strobes then precharges six cycles.

localparam int HADDR_W = 32;
localparam logic [19:0] BUS_CONTROL_IDX = 20'h4812e;
localparam logic [19:0] DRAM_TIMING_IDX = 20'h48130;
localparam logic [19:0] DRAM_STATUS_IDX = 20'h48132;
localparam logic [15:0] BUS_CONTROL_RST = 16'h0000;
localparam logic [15:0] DRAM_TIMING_RST = 16'h0000;
localparam logic [15:0] BUS_CONTROL_MASK = 16'h1fe0;
localparam logic [15:0] DRAM_TIMING_MASK = 16'h03db;
localparam int EDO_BIT = 12;
localparam int COL_LSB = 10;
localparam int REF_EN_BIT = 9;
localparam int REF_METH_BIT = 8;
localparam int RCAS_DLY_BIT = 7;
localparam int RRA_LSB = 5;
localparam int AREA_BIT = 9;
localparam int KEEP_BIT = 8;
localparam int PRC_LSB = 6;
localparam int CAS_COUNT_SEL_LSB = 3;
localparam int RAS_COUNT_SEL_LSB = 0;
// six precharge cycles, counter runs down to zero
localparam logic [2:0] SELF_EXIT_PRE_M1 = 3'h5;
localparam logic [2:0] HSIZE_BYTE = 3'h0;
localparam logic [2:0] HSIZE_HALF = 3'h1;

typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_RAS = 4'b0001,
    S_CAS = 4'b0010,
    S_PRE = 4'b0011,
    S_GAPE = 4'b0100,
    S_OPEN = 4'b0101,
    S_GAPS = 4'b0110,
    S_RFD = 4'b0111,
    S_RFR = 4'b1000,
    S_SELF = 4'b1001
} ddi_state_e;
endpackage

/* File: dv/ddi_dram_model.sv */
`timescale 1ns/100ps
module ddi_dram_model (
    input wire logic core_clk,
    input wire logic [23:0] dram_addr,
    input wire logic [15:0] dram_wdata,
    input wire logic dram_data_oe,
    output logic [15:0] dram_rdata_in,
    input wire logic [3:0] row_strobe_n,
    input wire logic high_col_strobe_n,
    input wire logic low_col_strobe_n,
    input wire logic dram_read_strobe_n,
    input wire logic dram_write_strobe_n
);
    logic [15:0] mem [256];
    logic [15:0] last = 16'h0000;
    logic [23:0] row_addr = '0;
    logic [23:0] col_addr = '0;
    logic rs_q = 1'b0;
    int rs_len = 0;
    int ras_len = 0;
    int cas_len = 0;
    int ref_cnt = 0;
    wire rs = row_strobe_n != 4'hf;
    wire cs = !high_col_strobe_n || !low_col_strobe_n;
    wire [7:0] k = dram_addr[7:0] ^ row_addr[7:0];
    // released bus toggles every cycle so stale data never looks valid
    // output stays on while the read strobe is low, as edo parts do
    assign dram_rdata_in = !dram_read_strobe_n ? mem[k] : ~last;
    always @(posedge core_clk)
    begin
        last <= dram_rdata_in;
        rs_q <= rs;
        if (rs && !rs_q)
        begin
            row_addr <= dram_addr;
            rs_len <= 1;
            ras_len <= int'(!cs);
            cas_len <= int'(cs);
            if (row_strobe_n == 4'h0)
                ref_cnt <= ref_cnt + 1;
        end
        else if (rs)
        begin
            rs_len <= rs_len + 1;
            ras_len <= ras_len + int'(!cs);
            cas_len <= cas_len + int'(cs);
        end
        if (cs)
            col_addr <= dram_addr;
        if (cs && !dram_write_strobe_n && dram_data_oe)
        begin
            if (!high_col_strobe_n)
                mem[k][15:8] <= dram_wdata[15:8];
            if (!low_col_strobe_n)
                mem[k][7:0] <= dram_wdata[7:0];
        end
    end
endmodule

/* File: dv/dram_direct_interface_control_bench.sv */
`timescale 1ns/100ps
`define CHK(got, exp) \
    begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module dram_direct_interface_control_bench;
    import ddi_pkg::*;
    logic core_clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, acc_ack, acc_rvalid, dram_data_oe;
    logic acc_req = 1'b0, acc_write = 1'b0, refresh_tick = 1'b0, ext_req = 1'b0;
    logic [27:0] acc_addr = '0;
    logic [15:0] acc_wdata = '0, acc_rdata, dram_wdata, dram_rdata_in, rdat;
    logic [23:0] dram_addr, m;
    logic [3:0] row_strobe_n;
    logic hcs_n, lcs_n, rds_n, wrs_n;
    logic [55:0] t;
    int num_errors = 0, checks_done = 0, lag, n;
    localparam logic [31:0] BC = {10'h0, BUS_CONTROL_IDX, 2'b00};
    localparam logic [31:0] TM = {10'h0, DRAM_TIMING_IDX, 2'b00};
    localparam logic [31:0] UNM = {10'h0, DRAM_STATUS_IDX + 20'h2, 2'b00};
    always #10 core_clk = ~core_clk;
    ddi_ctrl u_dut (.core_clk(core_clk), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .acc_req(acc_req),
        .acc_addr(acc_addr), .acc_write(acc_write), .acc_area(1'b0),
        .acc_be(2'h3), .acc_wdata(acc_wdata), .acc_ack(acc_ack),
        .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
        .refresh_tick(refresh_tick), .ext_bus_req(ext_req),
        .cpu_standby(1'b0), .dram_addr(dram_addr), .dram_wdata(dram_wdata),
        .dram_data_oe(dram_data_oe), .dram_rdata_in(dram_rdata_in),
        .row_strobe_n(row_strobe_n), .high_col_strobe_n(hcs_n),
        .low_col_strobe_n(lcs_n), .dram_read_strobe_n(rds_n),
        .dram_write_strobe_n(wrs_n));
    ddi_dram_model u_mem (.core_clk(core_clk), .dram_addr(dram_addr),
        .dram_wdata(dram_wdata), .dram_data_oe(dram_data_oe),
        .dram_rdata_in(dram_rdata_in), .row_strobe_n(row_strobe_n),
        .high_col_strobe_n(hcs_n), .low_col_strobe_n(lcs_n),
        .dram_read_strobe_n(rds_n), .dram_write_strobe_n(wrs_n));
    // ***********************************
    // bus tasks
    // ***********************************
    task automatic ahb(input logic w, input logic [31:0] a,
        input logic [2:0] sz, input logic [31:0] wd);
        @(posedge core_clk);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w; hsize <= sz;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        ahb(1'b1, a, 3'h2, d);
    endtask
    task automatic rr(input logic [31:0] a, input logic [31:0] e);
        ahb(1'b0, a, 3'h2, 32'h0);
        `CHK(rd, e)
        `CHK(hresp, 1'b0)
    endtask
    // fixed tail lets the precharge finish before the next request
    task automatic acc(input logic w, input logic [27:0] a,
        input logic [15:0] d);
        int c;
        @(posedge core_clk);
        acc_req <= 1'b1; acc_write <= w; acc_addr <= a; acc_wdata <= d;
        c = 0;
        do begin @(posedge core_clk); c++; end
        while (acc_ack !== 1'b1 && c < 100);
        acc_req <= 1'b0;
        lag = 0;
        while (!w && acc_rvalid !== 1'b1 && lag < 3)
        begin
            @(posedge core_clk);
            lag++;
        end
        rdat = acc_rdata;
        `CHK(c < 100, 1'b1)
        repeat (8) @(posedge core_clk);
    endtask
    task automatic tick;
        @(posedge core_clk) refresh_tick <= 1'b1;
        @(posedge core_clk) refresh_tick <= 1'b0;
        repeat (20) @(posedge core_clk);
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ***********************************
    // tests
    // ***********************************
    initial
    begin
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (5) @(posedge core_clk);
        rr(BC, 32'h0);
        rr(TM, 32'h0);
        wr(BC, 32'hfcff);
        rr(BC, {16'h0, BUS_CONTROL_MASK & 16'hfcff});
        wr(TM, 32'hffff);
        rr(TM, {16'h0, DRAM_TIMING_MASK});
        rr(UNM, 32'h0);
        wr(TM, 32'h0);
        ahb(1'b1, TM, HSIZE_BYTE, 32'h5a);
        rr(TM, {16'h0, 16'h5a5a & DRAM_TIMING_MASK});
        ahb(1'b1, TM + 1, HSIZE_BYTE, 32'hff00);
        rr(TM, {16'h0, 16'h5a5a & DRAM_TIMING_MASK});
        wr(BC, 32'h0);
        for (int j = 0; j < 4; j++)
        begin
            wr(TM, 32'(j * 73));
            acc(1'b1, 28'h0123456 + 28'(j), 16'hc3a0 + 16'(j));
            acc(1'b0, 28'h0123456 + 28'(j), 16'h0);
            `CHK(rdat, 16'hc3a0 + 16'(j))
            `CHK(u_mem.ras_len, j + 1)
            `CHK(u_mem.cas_len, j + 1)
        end
        wr(TM, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            wr(BC, 32'(i << 10));
            acc(1'b0, 28'hfedcba9, 16'h0);
            t = {28'hfffffff, 28'hfedcba9} >> (8 + i);
            m = (24'h1 << (8 + i)) - 24'h1;
            `CHK(u_mem.row_addr, t[23:0])
            `CHK(u_mem.col_addr & m, 24'hedcba9 & m)
        end
        wr(BC, 32'h0);
        acc(1'b0, 28'h0123456, 16'h0);
        `CHK(lag, 0)
        wr(BC, 32'h1000);
        acc(1'b0, 28'h0123456, 16'h0);
        `CHK(lag, 1)
        `CHK(rdat, 16'hc3a0)
        wr(BC, 32'h0);
        n = u_mem.ref_cnt;
        tick();
        `CHK(u_mem.ref_cnt, n)
        for (int k = 0; k < 4; k++)
        begin
            wr(BC, 32'h200 | 32'(k << 5));
            tick();
            `CHK(u_mem.ref_cnt, n + k + 1)
            `CHK(u_mem.rs_len, k + 2)
        end
        wr(BC, 32'h0);
        wr(BC, 32'h100);
        wr(BC, 32'h300);
        repeat (10) @(posedge core_clk);
        `CHK(row_strobe_n, 4'h0)
        wr(BC, 32'h100);
        repeat (10) @(posedge core_clk);
        `CHK(row_strobe_n, 4'hf)
        wr(BC, 32'h0);
        acc(1'b0, 28'h0123456, 16'h0);
        `CHK(rdat, 16'hc3a0)
        wr(TM, 32'h100);
        acc(1'b0, 28'h0123456, 16'h0);
        acc(1'b0, 28'h0123456, 16'h0);
        `CHK(rdat, 16'hc3a0)
        `CHK(u_mem.cas_len, 2)
        `CHK(row_strobe_n, 4'he)
        ext_req <= 1'b1;
        repeat (4) @(posedge core_clk);
        `CHK(row_strobe_n, 4'hf)
        wrap_up();
    end
    initial
    begin
        #400000;
        num_errors++;
        wrap_up();
    end
endmodule
